/* hw/urxfp_consts.vh */
// constants for the serial receiver with per-character error tracking
`ifndef URXFP_CONSTS_VH
`define URXFP_CONSTS_VH

// ***************************************************************
// register offsets
// ***************************************************************
`define URXFP_ADDR_CTRL 3'h0
`define URXFP_ADDR_BAUD_LO 3'h1
`define URXFP_ADDR_BAUD_HI 3'h2
`define URXFP_ADDR_ERR_FLAG 3'h3
`define URXFP_ADDR_ERR_IE 3'h4
`define URXFP_ADDR_RXB 3'h5
`define URXFP_ADDR_STATUS 3'h6

// ***************************************************************
// field positions
// ***************************************************************
`define URXFP_CTRL_ON_BIT 0
`define URXFP_CTRL_RXEN_BIT 1
`define URXFP_CTRL_MODE_LSB 4
`define URXFP_CTRL_MODE_MSB 7
`define URXFP_ERR_PE_BIT 0
`define URXFP_ERR_FE_BIT 1
`define URXFP_IE_PE_BIT 0
`define URXFP_IE_FE_BIT 1
`define URXFP_STAT_EMPTY_BIT 0
`define URXFP_STAT_FULL_BIT 1
`define URXFP_STAT_RXIF_BIT 2
`define URXFP_STAT_OVF_BIT 3

// ***************************************************************
// mode encodings
// ***************************************************************
`define URXFP_MODE_ODD 4'h2
`define URXFP_MODE_EVEN 4'h3

// ***************************************************************
// reset values and sizes
// ***************************************************************
`define URXFP_CTRL_RST 8'h00
`define URXFP_IE_RST 2'h0
`define URXFP_BAUD_RST 16'h01b1
`define URXFP_FIFO_DEPTH 4
`define URXFP_FIFO_AW 2
`define URXFP_ENTRY_W 10

`endif

/* hw/urxfp_sync.v */
// two-flop synchroniser for one asynchronous level
`timescale 1ns/1ns
module urxfp_sync
#(
  parameter RST_VAL = 1'b1
)
(
  input wire ref_clk,
  input wire rst_n,
  input wire async_in,
  output wire sync_out
);

  reg meta_r;
  reg stable_r;

  // first flop is read only by the second one
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_r <= RST_VAL;
      stable_r <= RST_VAL;
    end
    else
    begin
      meta_r <= async_in;
      stable_r <= meta_r;
    end
  end

  assign sync_out = stable_r;

endmodule // urxfp_sync

/* hw/urxfp_fifo.v */
// receive fifo holding each byte with its two error bits
`timescale 1ns/1ns
`include "urxfp_consts.vh"
module urxfp_fifo
(
  input wire ref_clk,
  input wire rst_n,
  input wire flush,
  input wire push,
  input wire [`URXFP_ENTRY_W-1:0] push_data,
  input wire pop,
  output wire [`URXFP_ENTRY_W-1:0] head_data,
  output wire empty,
  output wire full,
  output wire [`URXFP_FIFO_AW:0] level
);

  reg [`URXFP_ENTRY_W-1:0] mem_r [0:`URXFP_FIFO_DEPTH-1];
  reg [`URXFP_FIFO_AW-1:0] wr_ptr_r;
  reg [`URXFP_FIFO_AW-1:0] rd_ptr_r;
  reg [`URXFP_FIFO_AW:0] cnt_r;
  wire do_push;
  wire do_pop;

  assign empty = (cnt_r == {(`URXFP_FIFO_AW+1){1'b0}});
  // depth is a power of two, so only a full count sets the top bit
  assign full = cnt_r[`URXFP_FIFO_AW];
  assign do_push = push & ~full;
  assign do_pop = pop & ~empty;
  assign head_data = mem_r[rd_ptr_r];
  assign level = cnt_r;

  // storage has no reset; empty masks stale words
  always @(posedge ref_clk)
  begin
    if (do_push)
      mem_r[wr_ptr_r] <= push_data;
  end

  // pointers and occupancy, flush wins over push and pop
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr_r <= {`URXFP_FIFO_AW{1'b0}};
      rd_ptr_r <= {`URXFP_FIFO_AW{1'b0}};
      cnt_r <= {(`URXFP_FIFO_AW+1){1'b0}};
    end
    else if (flush)
    begin
      wr_ptr_r <= {`URXFP_FIFO_AW{1'b0}};
      rd_ptr_r <= {`URXFP_FIFO_AW{1'b0}};
      cnt_r <= {(`URXFP_FIFO_AW+1){1'b0}};
    end
    else
    begin
      if (do_push)
        wr_ptr_r <= wr_ptr_r + 1'b1;
      if (do_pop)
        rd_ptr_r <= rd_ptr_r + 1'b1;
      if (do_push && !do_pop)
        cnt_r <= cnt_r + 1'b1;
      else if (do_pop && !do_push)
        cnt_r <= cnt_r - 1'b1;
    end
  end

endmodule // urxfp_fifo

/* hw/urxfp_top.v */
// serial receiver with per-character framing and parity status
//
// The placing of the registers and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ns
`include "urxfp_consts.vh"
module urxfp_top
(
  input wire ref_clk,
  input wire rst_n,
  input wire [2:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output wire [7:0] reg_rdata,
  input wire rx_pin,
  output wire summary_err_irq,
  output wire rx_data_irq_flag
);

  // ***************************************************************
  // receive state machine encoding
  // ***************************************************************
  localparam ST_IDLE = 3'h0;
  localparam ST_START = 3'h1;
  localparam ST_DATA = 3'h2;
  localparam ST_PAR = 3'h3;
  localparam ST_STOP = 3'h4;

  // ***************************************************************
  // declarations
  // ***************************************************************
  reg [7:0] ctrl_r;
  reg [15:0] baud_r;
  reg [1:0] err_ie_r;
  reg ovf_r;
  reg ovf_nxt;
  reg [7:0] rdata_r;
  reg [7:0] rdata_nxt;
  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [15:0] baud_cnt_r;
  reg [15:0] baud_cnt_nxt;
  reg [2:0] bit_cnt_r;
  reg [2:0] bit_cnt_nxt;
  reg [7:0] shift_r;
  reg [7:0] shift_nxt;
  reg par_bit_r;
  reg par_bit_nxt;
  reg rx_prev_r;
  reg push_nxt;
  reg frame_err_nxt;
  reg parity_err_nxt;
  wire rx_s;
  wire mod_on;
  wire rx_en;
  wire [3:0] mode;
  wire par_mode;
  wire odd_sel;
  wire fall_edge;
  wire bit_tick;
  wire fifo_flush;
  wire fifo_pop;
  wire fifo_push;
  wire [`URXFP_ENTRY_W-1:0] push_word;
  wire [`URXFP_ENTRY_W-1:0] head_word;
  wire fifo_empty;
  wire fifo_full;
  wire [`URXFP_FIFO_AW:0] fifo_level;
  wire frame_err_flag;
  wire parity_err_flag;
  wire frame_err_irq_en;
  wire parity_err_irq_en;
  wire frame_hold;
  wire parity_hold;
  wire [7:0] error_flag_reg;
  wire [7:0] error_irq_enable_reg;
  wire [7:0] status_reg;
  wire wr_ctrl;
  wire wr_baud_lo;
  wire wr_baud_hi;
  wire wr_ie;
  wire wr_status;
  wire rd_rxb;

  // ***************************************************************
  // control decode
  // ***************************************************************
  assign mod_on = ctrl_r[`URXFP_CTRL_ON_BIT];
  assign rx_en = ctrl_r[`URXFP_CTRL_RXEN_BIT];
  assign mode = ctrl_r[`URXFP_CTRL_MODE_MSB:`URXFP_CTRL_MODE_LSB];
  // only the two parity encodings add a ninth bit
  assign par_mode = (mode == `URXFP_MODE_EVEN) ||
                    (mode == `URXFP_MODE_ODD);
  assign odd_sel = (mode == `URXFP_MODE_ODD);
  assign frame_err_irq_en = err_ie_r[`URXFP_IE_FE_BIT];
  assign parity_err_irq_en = err_ie_r[`URXFP_IE_PE_BIT];

  // ***************************************************************
  // bus strobes
  // ***************************************************************
  assign wr_ctrl = reg_wr && (reg_addr == `URXFP_ADDR_CTRL);
  assign wr_baud_lo = reg_wr && (reg_addr == `URXFP_ADDR_BAUD_LO);
  assign wr_baud_hi = reg_wr && (reg_addr == `URXFP_ADDR_BAUD_HI);
  assign wr_ie = reg_wr && (reg_addr == `URXFP_ADDR_ERR_IE);
  assign wr_status = reg_wr && (reg_addr == `URXFP_ADDR_STATUS);
  assign rd_rxb = reg_rd && (reg_addr == `URXFP_ADDR_RXB);

  // ***************************************************************
  // line input
  // ***************************************************************
  // line idles high, so the synchroniser resets high too
  urxfp_sync #(.RST_VAL(1'b1)) u_rx_sync
  (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .async_in(rx_pin),
    .sync_out(rx_s)
  );

  // previous level for start edge detection
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      rx_prev_r <= 1'b1;
    else
      rx_prev_r <= rx_s;
  end

  assign fall_edge = rx_prev_r & ~rx_s;
  // bit period is baud_r + 1 clocks; tick at count zero
  assign bit_tick = (baud_cnt_r == 16'h0000);

  // ***************************************************************
  // receive state machine
  // ***************************************************************
  // a start edge loads half a period so samples land mid bit
  always @*
  begin
    state_nxt = state_r;
    baud_cnt_nxt = baud_cnt_r;
    bit_cnt_nxt = bit_cnt_r;
    shift_nxt = shift_r;
    par_bit_nxt = par_bit_r;
    push_nxt = 1'b0;
    frame_err_nxt = 1'b0;
    parity_err_nxt = 1'b0;
    if (state_r != ST_IDLE)
    begin
      if (bit_tick)
        baud_cnt_nxt = baud_r;
      else
        baud_cnt_nxt = baud_cnt_r - 16'h0001;
    end
    case (state_r)
      ST_IDLE:
      begin
        bit_cnt_nxt = 3'h0;
        if (rx_en && fall_edge)
        begin
          state_nxt = ST_START;
          baud_cnt_nxt = {1'b0, baud_r[15:1]};
        end
      end
      ST_START:
      begin
        // a start bit gone high at mid bit was a glitch
        if (bit_tick)
          state_nxt = rx_s ? ST_IDLE : ST_DATA;
      end
      ST_DATA:
      begin
        if (bit_tick)
        begin
          shift_nxt = {rx_s, shift_r[7:1]};
          bit_cnt_nxt = bit_cnt_r + 3'h1;
          if (bit_cnt_r == 3'h7)
            state_nxt = par_mode ? ST_PAR : ST_STOP;
        end
      end
      ST_PAR:
      begin
        if (bit_tick)
        begin
          par_bit_nxt = rx_s;
          state_nxt = ST_STOP;
        end
      end
      ST_STOP:
      begin
        if (bit_tick)
        begin
          push_nxt = 1'b1;
          frame_err_nxt = ~rx_s;
          // total ones odd in even mode, even in odd mode
          parity_err_nxt = par_mode &
                           ((^{shift_r, par_bit_r}) ^ odd_sel);
          // back to idle even on a bad stop bit
          state_nxt = ST_IDLE;
        end
      end
      default:
      begin
        state_nxt = ST_IDLE;
      end
    endcase
    // a disabled module abandons any frame in progress
    if (!mod_on)
      state_nxt = ST_IDLE;
  end

  // receive state registers
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= ST_IDLE;
      baud_cnt_r <= 16'h0000;
      bit_cnt_r <= 3'h0;
      shift_r <= 8'h00;
      par_bit_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      baud_cnt_r <= baud_cnt_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      shift_r <= shift_nxt;
      par_bit_r <= par_bit_nxt;
    end
  end

  // ***************************************************************
  // receive fifo
  // ***************************************************************
  // byte and both error bits travel as one word
  assign push_word = {frame_err_nxt, parity_err_nxt, shift_r};
  assign fifo_push = push_nxt & mod_on;
  assign fifo_flush = ~mod_on;
  assign fifo_pop = rd_rxb & mod_on;

  urxfp_fifo u_rx_fifo
  (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .flush(fifo_flush),
    .push(fifo_push),
    .push_data(push_word),
    .pop(fifo_pop),
    .head_data(head_word),
    .empty(fifo_empty),
    .full(fifo_full),
    .level(fifo_level)
  );

  // ***************************************************************
  // head status and interrupt outputs
  // ***************************************************************
  // an empty fifo masks whatever stale word sits at the head
  assign frame_err_flag = ~fifo_empty & head_word[9];
  // mismatch bit, the received parity bit is never stored
  assign parity_err_flag = ~fifo_empty & head_word[8];
  assign frame_hold = frame_err_irq_en & frame_err_flag;
  assign parity_hold = parity_err_irq_en & parity_err_flag;
  assign summary_err_irq = frame_hold | parity_hold;
  // data flag is a level: set while a head with no enabled error waits
  assign rx_data_irq_flag = ~fifo_empty & ~frame_hold &
                            ~parity_hold;

  // ***************************************************************
  // software registers
  // ***************************************************************
  // overrun: a full fifo drops the character; set wins over clear
  always @*
  begin
    ovf_nxt = ovf_r;
    if (wr_status && reg_wdata[`URXFP_STAT_OVF_BIT])
      ovf_nxt = 1'b0;
    if (push_nxt && mod_on && fifo_full)
      ovf_nxt = 1'b1;
    if (!mod_on)
      ovf_nxt = 1'b0;
  end

  // writable registers; flag and buffer writes are dropped
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_r <= `URXFP_CTRL_RST;
      baud_r <= `URXFP_BAUD_RST;
      err_ie_r <= `URXFP_IE_RST;
      ovf_r <= 1'b0;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_r <= reg_wdata;
      if (wr_baud_lo)
        baud_r[7:0] <= reg_wdata;
      if (wr_baud_hi)
        baud_r[15:8] <= reg_wdata;
      if (wr_ie)
      begin
        err_ie_r[`URXFP_IE_FE_BIT] <= reg_wdata[`URXFP_IE_FE_BIT];
        err_ie_r[`URXFP_IE_PE_BIT] <= reg_wdata[`URXFP_IE_PE_BIT];
      end
      ovf_r <= ovf_nxt;
    end
  end

  // read views, unused bits read as zero
  assign error_flag_reg = {6'h00, frame_err_flag,
                           parity_err_flag};
  assign error_irq_enable_reg = {6'h00, err_ie_r};
  assign status_reg = {1'b0, fifo_level, ovf_r, rx_data_irq_flag,
                       fifo_full, fifo_empty};

  // ***************************************************************
  // read data path
  // ***************************************************************
  // data stands only in the cycle after the strobe
  always @*
  begin
    rdata_nxt = 8'h00;
    if (reg_rd)
    begin
      case (reg_addr)
        `URXFP_ADDR_CTRL: rdata_nxt = ctrl_r;
        `URXFP_ADDR_BAUD_LO: rdata_nxt = baud_r[7:0];
        `URXFP_ADDR_BAUD_HI: rdata_nxt = baud_r[15:8];
        `URXFP_ADDR_ERR_FLAG: rdata_nxt = error_flag_reg;
        `URXFP_ADDR_ERR_IE: rdata_nxt = error_irq_enable_reg;
        // empty buffer reads zero and pops nothing
        `URXFP_ADDR_RXB: rdata_nxt = fifo_empty ? 8'h00 :
                                     head_word[7:0];
        `URXFP_ADDR_STATUS: rdata_nxt = status_reg;
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  // registered read data
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata_r <= 8'h00;
    else
      rdata_r <= rdata_nxt;
  end

  assign reg_rdata = rdata_r;

endmodule // urxfp_top

/* tb/urxfp_monitor.sv */
// concurrent checks on the receiver register port and irq outputs
`timescale 1ns/1ns
module urxfp_monitor
(
  input wire ref_clk,
  input wire rst_n,
  input wire [2:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  input wire rx_pin,
  input wire summary_err_irq,
  input wire rx_data_irq_flag
);
  reg [1:0] ie_r;
  reg on_r;
  // shadow of the enables, so each check knows which errors count
  always @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
    begin
      ie_r <= 2'h0;
      on_r <= 1'b0;
    end
    else if (reg_wr)
    begin
      if (reg_addr == 3'h4) ie_r <= reg_wdata[1:0];
      if (reg_addr == 3'h0) on_r <= reg_wdata[0];
    end

  // ****************
  // properties
  // ****************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // a read strobe followed by its data cycle
  sequence s_flag_rd;
    reg_rd && reg_addr == 3'h3 ##1 1'b1;
  endsequence
  sequence s_stat_rd;
    reg_rd && reg_addr == 3'h6 ##1 1'b1;
  endsequence

  a_err_bits_only: assert property (s_flag_rd |-> reg_rdata[7:2] == 6'h00)
    else $error("error flag register shows stray bits");
  a_frame_summary: assert property (s_flag_rd ##0 ie_r == 2'h2 |->
    $past(summary_err_irq) == reg_rdata[1])
    else $error("summary irq disagrees with head framing flag");
  a_parity_summary: assert property (s_flag_rd ##0 ie_r == 2'h1 |->
    $past(summary_err_irq) == reg_rdata[0])
    else $error("summary irq disagrees with head parity flag");
  a_irq_exclusive: assert property (summary_err_irq |-> !rx_data_irq_flag)
    else $error("data flag not held off by enabled head error");
  a_empty_quiet: assert property (s_stat_rd ##0 reg_rdata[0] |->
    !$past(summary_err_irq) && !$past(rx_data_irq_flag))
    else $error("irq output high while fifo empty");
  a_flag_mirror: assert property (s_stat_rd |->
    reg_rdata[2] == $past(rx_data_irq_flag))
    else $error("status data flag differs from output");
  a_clean_flag: assert property (s_stat_rd ##0 ie_r == 2'h0 |->
    reg_rdata[2] == !reg_rdata[0])
    else $error("data flag not equal to fifo non-empty");
  a_off_silent: assert property (!on_r [*2] |->
    !summary_err_irq && !rx_data_irq_flag)
    else $error("irq output high while module off");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside read cycle");
endmodule // urxfp_monitor

bind urxfp_top urxfp_monitor u_mon (.ref_clk, .rst_n, .reg_addr, .reg_wdata,
  .reg_wr, .reg_rd, .reg_rdata, .rx_pin, .summary_err_irq, .rx_data_irq_flag);

/* tb/urxfp_tx_model.sv */
// line-side model of the remote serial transmitter
`timescale 1ns/1ns
module urxfp_tx_model
#(
  parameter BIT_CLKS = 16
)
(
  input wire ref_clk,
  output reg rx_pin
);
  // line idles high between frames
  initial rx_pin = 1'b1;
  // start, eight data bits lsb first, optional parity, one stop bit
  task send_char(input [7:0] data, input par_on, input par_bit,
    input stop_bit, input integer gap);
    integer i;
    reg [10:0] frame;
    begin
      frame = {stop_bit, par_bit, data, 1'b0};
      for (i = 0; i < 11; i = i + 1)
        if (i != 9 || par_on)
        begin
          @(posedge ref_clk);
          rx_pin <= frame[i];
          repeat (BIT_CLKS - 1) @(posedge ref_clk);
        end
      // a low stop bit must end high again, or no new start is seen
      @(posedge ref_clk);
      rx_pin <= 1'b1;
      repeat (gap) @(posedge ref_clk);
    end
  endtask
endmodule // urxfp_tx_model

/* tb/uart_rx_frame_parity_errors_tb.sv */
// self-checking bench for the receiver per-character error tracking
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_compared = n_compared + 1; \
  if ((g) !== (e)) begin mismatches = mismatches + 1; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module uart_rx_frame_parity_errors_tb;
  reg ref_clk = 1'b0;
  reg rst_n;
  reg [2:0] reg_addr;
  reg [7:0] reg_wdata;
  reg reg_wr;
  reg reg_rd;
  wire [7:0] reg_rdata;
  wire rx_pin;
  wire summary_err_irq;
  wire rx_data_irq_flag;
  integer mismatches;
  integer n_compared;
  integer mi;
  integer i;
  integer seed;
  reg [3:0] m;
  reg [7:0] rd_v;
  reg [1:0] ie_v;
  reg [9:0] exp_q [$];
  reg [7:0] rst_tab [0:7];

  // 50 MHz clock
  always #10 ref_clk = ~ref_clk;

  urxfp_top uut (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .rx_pin(rx_pin),
    .summary_err_irq(summary_err_irq), .rx_data_irq_flag(rx_data_irq_flag));
  // baud register is set to 0x0f, so sixteen clocks a bit
  urxfp_tx_model #(.BIT_CLKS(16)) tx (.ref_clk(ref_clk), .rx_pin(rx_pin));

  // ****************
  // bus tasks and expectations
  // ****************
  task wr(input [2:0] a, input [7:0] d);
    begin
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
    end
  endtask
  // data stands only in the cycle after the strobe
  task rd(input [2:0] a, output [7:0] d);
    begin
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
    end
  endtask
  function pe_of(input [3:0] md, input [7:0] d, input p);
    pe_of = (md == 4'h3) ? ^{d, p} : (md == 4'h2) ? ~^{d, p} : 1'b0;
  endfunction
  task send(input [3:0] md, input fe, input [7:0] d, input p);
    begin
      tx.send_char(d, md == 4'h2 || md == 4'h3, p, ~fe, 16 * (1 + $urandom % 3));
      exp_q.push_back({fe, pe_of(md, d, p), d});
    end
  endtask
  // flags are read before the byte, since reading the byte pops the head
  task check_head(input [1:0] ie);
    reg [9:0] e;
    begin
      e = exp_q.pop_front();
      wr(3'h4, {6'h00, ie});
      rd(3'h3, rd_v);
      `CHK("err_flag", {6'h00, e[9:8]}, rd_v)
      `CHK("summary", |(e[9:8] & ie), summary_err_irq)
      `CHK("data_flag", ~|(e[9:8] & ie), rx_data_irq_flag)
      rd(3'h5, rd_v);
      `CHK("rx_byte", e[7:0], rd_v)
    end
  endtask
  task stop_test;
    begin
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask

  // ****************
  // main sequence
  // ****************
  initial
  begin
    mismatches = 0;
    n_compared = 0;
    rst_n = 1'b0;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    rst_tab[0] = 8'h00;
    rst_tab[1] = 8'hb1;
    rst_tab[2] = 8'h01;
    rst_tab[3] = 8'h00;
    rst_tab[4] = 8'h00;
    rst_tab[5] = 8'h00;
    rst_tab[6] = 8'h01;
    rst_tab[7] = 8'h00;
    seed = $urandom(18);
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    for (i = 0; i < 8; i = i + 1)
    begin
      rd(i[2:0], rd_v);
      `CHK("reset_value", rst_tab[i], rd_v)
    end
    wr(3'h1, 8'h0f);
    wr(3'h2, 8'h00);
    // plain, odd and even parity modes, four characters each
    for (mi = 0; mi < 3; mi = mi + 1)
    begin
      m = (mi == 0) ? 4'h0 : (mi == 1) ? 4'h2 : 4'h3;
      wr(3'h0, {m, 4'h3});
      wr(3'h4, 8'h00);
      send(m, 1'b1, $urandom, $urandom);
      for (i = 0; i < 3; i = i + 1)
        send(m, $urandom % 3 == 0, $urandom, $urandom);
      rd(3'h6, rd_v);
      `CHK("status_full", 8'h46, rd_v)
      wr(3'h3, 8'h00);
      rd(3'h3, rd_v);
      `CHK("flag_ro", {6'h00, exp_q[0][9:8]}, rd_v)
      // first two heads pin one enable each, so both summary paths are hit
      for (i = 0; i < 4; i = i + 1)
      begin
        ie_v = $urandom;
        if (i == 0)
          ie_v = 2'h2;
        if (i == 1)
          ie_v = 2'h1;
        check_head(ie_v);
      end
      rd(3'h3, rd_v);
      `CHK("flag_empty", 8'h00, rd_v)
      `CHK("summary_empty", 1'b0, summary_err_irq)
    end
    // turning the module off flushes stored errors
    send(4'h3, 1'b1, $urandom, $urandom);
    send(4'h3, 1'b0, $urandom, $urandom);
    wr(3'h4, 8'h03);
    #1 `CHK("summary_set", 1'b1, summary_err_irq)
    wr(3'h0, 8'h00);
    rd(3'h6, rd_v);
    `CHK("status_flushed", 8'h01, rd_v)
    rd(3'h3, rd_v);
    `CHK("flag_flushed", 8'h00, rd_v)
    `CHK("summary_flushed", 1'b0, summary_err_irq)
    exp_q.delete();
    wr(3'h0, 8'h33);
    // five clean characters: the fifth meets a full fifo and is dropped
    for (i = 0; i < 5; i = i + 1)
    begin
      rd_v = 8'ha5 + i[7:0];
      send(4'h3, 1'b0, rd_v, ^rd_v);
    end
    exp_q.delete(4);
    rd(3'h6, rd_v);
    `CHK("status_overrun", 8'h4e, rd_v)
    wr(3'h6, 8'h08);
    rd(3'h6, rd_v);
    `CHK("status_ovf_clear", 8'h46, rd_v)
    for (i = 0; i < 4; i = i + 1)
      check_head(2'h3);
    `CHK("summary_drained", 1'b0, summary_err_irq)
    stop_test;
  end

  // watchdog, well above the expected run of some 4000 cycles
  initial
  begin
    repeat (30000) @(posedge ref_clk);
    mismatches = mismatches + 1;
    stop_test;
  end
endmodule // uart_rx_frame_parity_errors_tb
